// [subtract_xor_swap_alu.sv]
// Purpose: datapath slice running subtract, xor and nibble swap with flag updates
// Assumes: one clock, asynchronous active-high reset, single AHB-Lite master
// Notes:   every transfer takes one wait state; command writes execute in it
`timescale 1ns/1ps

module subtract_xor_swap_alu (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp
);
    import alu_ops_pkg::*;

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------

    // subtract b from a, carry and digit carry are the inverted borrows
    function automatic sub_result_t sub8(input logic [7:0] a, input logic [7:0] b);
        logic [8:0]  full;
        logic [4:0]  low;
        sub_result_t r;
        full = {1'b0, a} + {1'b0, ~b} + 9'h001;
        low  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
        r.value            = full[7:0];
        r.carry            = full[8];
        r.digit_carry_flag = low[4];
        return r;
    endfunction

    // true when the word address falls in the file register window
    function automatic logic in_file(input logic [31:0] a);
        return (a[31:12] == 20'h00000) && (a[11:9] == FILE_REGION);
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    bus_state_t  state_q, state_d;
    logic [31:0] addr_q, addr_d;
    logic        write_q, write_d;
    logic        ready_q, ready_d;
    logic [31:0] rdata_q, rdata_d;
    logic        resp_q;

    logic [7:0]  acc_q, acc_d;
    flags_t      flags_q, flags_d;
    cmd_t        cmd_q, cmd_d;
    logic [7:0]  file_q [FILE_DEPTH];
    logic [7:0]  file_d [FILE_DEPTH];

    logic        exec;
    cmd_t        cmd_in;
    logic [7:0]  operand;
    sub_result_t sub_r;
    logic [7:0]  result;
    logic        to_acc_only;
    logic        keep_flags;
    logic        zero_only;

    // ------------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------------

    // take the address phase, then one wait state for write or read fetch
    always_comb begin
        state_d = state_q;
        addr_d  = addr_q;
        write_d = write_q;
        ready_d = ready_q;
        rdata_d = rdata_q;
        case (state_q)
            BUS_IDLE: begin
                ready_d = 1'b1;
                if (hsel && htrans[1] && hready) begin
                    addr_d  = haddr;
                    write_d = hwrite;
                    ready_d = 1'b0;
                    state_d = BUS_WAIT;
                end
            end
            BUS_WAIT: begin
                ready_d = 1'b1;
                state_d = BUS_IDLE;
                if (!write_q) begin
                    rdata_d = RDATA_ZERO;           // unmapped reads give zero
                    if (in_file(addr_q)) begin
                        rdata_d = {24'h000000, file_q[addr_q[8:2]]};
                    end else if (addr_q == {20'h00000, CMD_OFS}) begin
                        rdata_d = cmd_q;
                    end else if (addr_q == {20'h00000, ACC_OFS}) begin
                        rdata_d = {24'h000000, acc_q};
                    end else if (addr_q == {20'h00000, FLAGS_OFS}) begin
                        rdata_d = {29'h00000000, flags_q};
                    end
                end
            end
            default: begin
                state_d = BUS_IDLE;
                ready_d = 1'b1;
            end
        endcase
    end

    // bus registers, response is always okay
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= BUS_IDLE;
            addr_q  <= 32'h00000000;
            write_q <= 1'b0;
            ready_q <= 1'b1;
            rdata_q <= RDATA_ZERO;
            resp_q  <= HRESP_OKAY;
        end else begin
            state_q <= state_d;
            addr_q  <= addr_d;
            write_q <= write_d;
            ready_q <= ready_d;
            rdata_q <= rdata_d;
            resp_q  <= HRESP_OKAY;
        end
    end

    assign hrdata    = rdata_q;
    assign hreadyout = ready_q;
    assign hresp     = resp_q;

    // ------------------------------------------------------------------
    // operation datapath
    // ------------------------------------------------------------------

    // a command write in the wait state runs one operation
    assign exec    = (state_q == BUS_WAIT) && write_q && (addr_q == {20'h00000, CMD_OFS});
    assign cmd_in  = cmd_t'(hwdata);
    assign operand = file_q[cmd_in.addr];

    // compute the result and how it affects flags
    always_comb begin
        sub_r       = sub8(operand, acc_q);
        result      = acc_q;
        to_acc_only = 1'b0;
        keep_flags  = 1'b1;
        zero_only   = 1'b0;
        case (op_t'(cmd_in.op))
            literal_minus_acc_op: begin
                sub_r       = sub8(cmd_in.literal, acc_q);
                result      = sub_r.value;
                to_acc_only = 1'b1;
                keep_flags  = 1'b0;
            end
            acc_xor_literal_op: begin
                result      = acc_q ^ cmd_in.literal;
                to_acc_only = 1'b1;
                keep_flags  = 1'b0;
                zero_only   = 1'b1;
            end
            reg_minus_acc_op: begin
                result     = sub_r.value;
                keep_flags = 1'b0;
            end
            acc_xor_reg_op: begin
                result     = acc_q ^ operand;
                keep_flags = 1'b0;
                zero_only  = 1'b1;
            end
            nibble_swap_op: begin
                result = {operand[3:0], operand[7:4]};
            end
            default: begin
                result = acc_q;                     // unused codes leave acc, flags and file unchanged
            end
        endcase
    end

    // next values of accumulator, flags, command and file registers
    always_comb begin
        acc_d   = acc_q;
        flags_d = flags_q;
        cmd_d   = cmd_q;
        file_d  = file_q;
        if (exec) begin
            cmd_d = cmd_in;
            if (op_t'(cmd_in.op) inside {literal_minus_acc_op, acc_xor_literal_op,
                                         reg_minus_acc_op, acc_xor_reg_op,
                                         nibble_swap_op}) begin
                if (to_acc_only || (cmd_in.dest == DEST_ACC)) begin
                    acc_d = result;
                end else begin
                    file_d[cmd_in.addr] = result;
                end
            end
            if (!keep_flags) begin
                flags_d.zero = (result == 8'h00);
                if (!zero_only) begin
                    flags_d.carry            = sub_r.carry;
                    flags_d.digit_carry_flag = sub_r.digit_carry_flag;
                end
            end
        end else if ((state_q == BUS_WAIT) && write_q) begin
            if (in_file(addr_q)) begin
                file_d[addr_q[8:2]] = hwdata[7:0];
            end else if (addr_q == {20'h00000, ACC_OFS}) begin
                acc_d = hwdata[7:0];
            end else if (addr_q == {20'h00000, FLAGS_OFS}) begin
                flags_d = flags_t'(hwdata[2:0]);
            end
        end
    end

    // datapath registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            acc_q   <= ACC_RESET;
            flags_q <= flags_t'(FLAGS_RESET);
            cmd_q   <= cmd_t'(CMD_RESET);
            for (int i = 0; i < FILE_DEPTH; i++) begin
                file_q[i] <= FILE_RESET;
            end
        end else begin
            acc_q   <= acc_d;
            flags_q <= flags_d;
            cmd_q   <= cmd_d;
            file_q  <= file_d;
        end
    end

endmodule

// [alu_ops_pkg.sv]
// Purpose: shared constants and types for the subtract / xor / swap datapath slice
// Assumes: 32-bit AHB-Lite register access, word transfers only
// Notes:   byte offsets below are the register map seen by software
package alu_ops_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [11:0] CMD_OFS     = 12'h000;  // command, write runs one operation
    localparam logic [11:0] ACC_OFS     = 12'h004;  // accumulator
    localparam logic [11:0] FLAGS_OFS   = 12'h008;  // zero, digit carry, carry
    localparam logic [2:0]  FILE_REGION = 3'h1;     // addr[11:9], file window 0x200-0x3FC
    localparam int          FILE_DEPTH  = 128;

    // ------------------------------------------------------------------
    // reset values and encodings
    // ------------------------------------------------------------------
    localparam logic [7:0]  ACC_RESET   = 8'h00;
    localparam logic [7:0]  FILE_RESET  = 8'h00;
    localparam logic [31:0] CMD_RESET   = 32'h00000000;
    localparam logic [2:0]  FLAGS_RESET = 3'h0;
    localparam logic [31:0] RDATA_ZERO  = 32'h00000000;
    localparam logic        DEST_ACC    = 1'b0;
    localparam logic        DEST_FILE   = 1'b1;
    localparam logic        HRESP_OKAY  = 1'b0;

    typedef enum logic [2:0] {
        literal_minus_acc_op = 3'h0,
        acc_xor_literal_op   = 3'h1,
        reg_minus_acc_op     = 3'h2,
        acc_xor_reg_op       = 3'h3,
        nibble_swap_op       = 3'h4
    } op_t;

    // command word: literal in [23:16], file address in [10:4], dest in [3], op in [2:0]
    typedef struct packed {
        logic [7:0] pad_hi;
        logic [7:0] literal;
        logic [4:0] pad_mid;
        logic [6:0] addr;
        logic       dest;
        logic [2:0] op;
    } cmd_t;

    // status flags as read at FLAGS_OFS: bit2 zero, bit1 digit carry, bit0 carry
    typedef struct packed {
        logic zero;
        logic digit_carry_flag;
        logic carry;
    } flags_t;

    typedef struct packed {
        logic       carry;
        logic       digit_carry_flag;
        logic [7:0] value;
    } sub_result_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_WAIT = 2'b10
    } bus_state_t;

endpackage

// [alu_bus_check_assertions.sv]
// Purpose: bus timing and read-back checks for the alu slice
// Assumes: one slave, hready driven from hreadyout
// Notes:   sees the top-level ports only
`timescale 1ns/1ps

module alu_bus_check
    import alu_ops_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    input  wire logic        hreadyout,
    input  wire logic        hresp
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // read address phase taken while idle
    wire rd_tk = hsel && htrans[1] && hready && hreadyout && !hwrite;

    // one wait state per transfer, none otherwise
    take_wait_a: assert property (hsel && htrans[1] && hready && hreadyout |=> !hreadyout)
        else $error("no wait state after address phase");
    wait_end_a: assert property (!hreadyout |=> hreadyout)
        else $error("wait state longer than one cycle");
    idle_ready_a: assert property (hreadyout && !(hsel && htrans[1] && hready) |=> hreadyout)
        else $error("wait state without a transfer");
    resp_okay_a: assert property (hresp == HRESP_OKAY)
        else $error("response not okay");
    // read data moves only at the end of a wait state
    rdata_hold_a: assert property ($changed(hrdata) |-> $past(hreadyout) == 1'b0)
        else $error("read data changed outside a read");
    unmapped_zero_a: assert property (rd_tk && haddr == 32'h100 |-> ##2 hrdata == RDATA_ZERO)
        else $error("unmapped read not zero");
    acc_upper_a: assert property (rd_tk && haddr[11:0] == ACC_OFS |-> ##2 hrdata[31:8] == 24'h0)
        else $error("accumulator upper bits not zero");
    flags_upper_a: assert property (rd_tk && haddr[11:0] == FLAGS_OFS |-> ##2 hrdata[31:3] == 29'h0)
        else $error("flags upper bits not zero");
endmodule

bind subtract_xor_swap_alu alu_bus_check i_chk (.clk(clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

// [subtract_xor_swap_alu_ops_bench.sv]
// Purpose: self-checking bench for the alu slice over its register bus
// Assumes: one slave, hready driven from hreadyout
// Notes:   a shadow model predicts every read-back
`timescale 1ns/1ps

module subtract_xor_swap_alu_ops_bench;
    import alu_ops_pkg::*;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    wire         hready = hreadyout;
    int          n_fail = 0;
    int          checks = 0;
    int          cyc = 0;
    logic [7:0]  lf = 8'h1E;
    logic [7:0]  acc = ACC_RESET;
    logic [7:0]  mem [FILE_DEPTH];
    flags_t      fl = FLAGS_RESET;
    logic [31:0] expq [$];
    logic [31:0] e;
    logic [31:0] ra = 32'h0;
    logic        dph = 1'b0;
    logic [7:0]  v;
    logic [7:0]  k;
    logic [6:0]  f;
    logic [2:0]  o;

    always #4 clk = ~clk;

    subtract_xor_swap_alu i_dut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

    // pseudo-random byte source
    function automatic logic [7:0] rnd();
        lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
        return lf;
    endfunction

    function automatic logic [31:0] fa(input logic [6:0] n);
        return {20'h0, FILE_REGION, n, 2'b00};
    endfunction

    task automatic complete_run();
        if (n_fail == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // one single transfer: address phase, then data phase
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= w ? d : {24'h0, rnd()};
        do @(posedge clk); while (hready !== 1'b1);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] x);
        expq.push_back(x);
        xfer(1'b0, a, 32'h0);
    endtask

    // issue a command and update the shadow model
    task automatic run_op(input logic [2:0] c, input logic d, input logic [6:0] n);
        logic [7:0] a;
        logic [7:0] r;
        xfer(1'b1, {20'h0, CMD_OFS}, {8'h0, k, 5'h0, n, d, c});
        a = (c == literal_minus_acc_op) ? k : mem[n];
        case (c)
            literal_minus_acc_op, reg_minus_acc_op: begin
                r = a - acc;
                fl = '{r == 8'h00, a[3:0] >= acc[3:0], a >= acc};
            end
            acc_xor_literal_op, acc_xor_reg_op: begin
                r = acc ^ ((c == acc_xor_literal_op) ? k : mem[n]);
                fl.zero = (r == 8'h00);
            end
            nibble_swap_op: r = {mem[n][3:0], mem[n][7:4]};
            default: return;
        endcase
        if (c < 3'h2 || d == DEST_ACC) acc = r;
        else mem[n] = r;
    endtask

    // compare each completed read with the oldest note
    always @(posedge clk) begin
        if (dph && hreadyout === 1'b1) begin
            checks++;
            e = expq.pop_front();
            if (hrdata !== e) begin
                $display("MISMATCH hrdata %h expected %h seen %h", ra, e, hrdata);
                n_fail++;
            end
            if (hresp !== HRESP_OKAY) begin
                $display("MISMATCH hresp expected %h seen %h", HRESP_OKAY, hresp);
                n_fail++;
            end
        end
        if (hreadyout === 1'b1) begin
            dph = hsel && htrans[1] && !hwrite;
            ra = haddr;
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            complete_run();
        end
    end

    initial begin
        for (int i = 0; i < FILE_DEPTH; i++) mem[i] = FILE_RESET;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        rd({20'h0, FLAGS_OFS}, {29'h0, FLAGS_RESET});
        rd(32'h100, RDATA_ZERO);
        for (int i = 0; i < 64; i++) begin
            acc = rnd();
            xfer(1'b1, {20'h0, ACC_OFS}, {24'h0, acc});
            f = 7'(rnd());
            v = (i % 3 == 0) ? acc : rnd();
            mem[f] = v;
            xfer(1'b1, fa(f), {24'h0, v});
            v = rnd();
            fl = v[2:0];
            xfer(1'b1, {20'h0, FLAGS_OFS}, {29'h0, v[2:0]});
            k = (i % 4 == 1) ? acc : rnd();
            o = (i < 16) ? 3'(i % 8) : 3'(rnd());
            v = rnd();
            run_op(o, v[0], f);
            rd({20'h0, CMD_OFS}, {8'h0, k, 5'h0, f, v[0], o});
            rd({20'h0, ACC_OFS}, {24'h0, acc});
            rd({20'h0, FLAGS_OFS}, {29'h0, fl});
            rd(fa(f), {24'h0, mem[f]});
        end
        @(posedge clk);
        complete_run();
    end
endmodule
